// ==== include/sdb_pkg.sv ====
// constants and state type for the speed-detect / brake configuration bank
// assumes a single 50 MHz clock domain and a 32-bit word register port

package sdb_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int          NUM_REGS = 13;
    localparam int          ADDR_W   = 12;
    localparam logic [11:0] REG_OFFS [NUM_REGS] = '{
        12'h080, 12'h082, 12'h084, 12'h086, 12'h088, 12'h08a, 12'h08c,
        12'h08e, 12'h090, 12'h096, 12'h098, 12'h09a, 12'h09c};
    localparam int          DET_IDX   = 0;
    localparam logic [31:0] RESET_VAL = 32'h0000_0000;

    // ************************************************************
    // initial-speed-detect field positions
    // ************************************************************
    localparam int PARITY_BIT    = 31;
    localparam int DETECT_EN_BIT = 30;
    localparam int BRAKE_EN_BIT  = 29;
    localparam int FLOAT_EN_BIT  = 28;
    localparam int REVERSE_BIT   = 27;
    localparam int RESYNC_BIT    = 26;
    localparam int STAND_BRK_BIT = 25;
    localparam int EMF_THR_LSB   = 22;
    localparam int SWITCH_BIT    = 21;
    localparam int EXIT_SEL_BIT  = 20;
    localparam int CUR_LIM_LSB   = 17;
    localparam int BRK_DUR_LSB   = 13;
    localparam int FLOAT_DUR_LSB = 9;
    localparam int STAND_DUR_LSB = 6;
    localparam int RESYNC_MV_LSB = 3;

    // ************************************************************
    // code to physical value tables (mV or ms)
    // ************************************************************
    localparam logic [6:0]  THR_MV [8] = '{
        7'h05, 7'h0a, 7'h0f, 7'h14, 7'h19, 7'h1e, 7'h32, 7'h64};
    localparam logic [13:0] DUR_MS [16] = '{
        14'h000a, 14'h0032, 14'h0064, 14'h00c8, 14'h012c, 14'h0190,
        14'h01f4, 14'h02ee, 14'h03e8, 14'h07d0, 14'h0bb8, 14'h0fa0,
        14'h1388, 14'h1d4c, 14'h2710, 14'h3a98};
    localparam logic [9:0]  STAND_MS [8] = '{
        10'h001, 10'h00a, 10'h019, 10'h032, 10'h064, 10'h0fa,
        10'h1f4, 10'h3e8};
    localparam logic [10:0] RESYNC_MV [8] = '{
        11'h000, 11'h12c, 11'h190, 11'h1f4, 11'h258, 11'h320,
        11'h3e8, 11'h4e2};

    // ************************************************************
    // block state
    // ************************************************************
    typedef struct packed {
        logic [NUM_REGS-1:0][31:0] bank;
        logic [31:0]               rdData;
        logic                      rdValid;
        logic                      addrErr;
        logic [6:0]                emfMv;
        logic [6:0]                curMv;
        logic [13:0]               brkMs;
        logic [13:0]               floatMs;
        logic [9:0]                standMs;
        logic [10:0]               resyncMv;
    } sdb_state_s;

endpackage

// ==== design/sdb_config_bank.sv ====
// configuration bank for the initial-speed-detect and brake settings
// assumes the serial front end delivers whole 32-bit words and address
// strobes synchronous to ref_clk; the motor algorithm reads the fields

`timescale 1ns/1ns

module sdb_config_bank
    import sdb_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    // register port
    input  wire logic              cfgWrite,
    input  wire logic              cfgRead,
    input  wire logic [ADDR_W-1:0] cfgAddr,
    input  wire logic [31:0]       cfgWrData,
    output logic      [31:0]       cfgRdData,
    output logic                   cfgRdValid,
    output logic                   cfgAddrErr,
    // single-bit settings to the motor algorithm
    output logic                   speedDetectEnable,
    output logic                   brakeEnable,
    output logic                   floatOutputsEnable,
    output logic                   reverseDriveEnable,
    output logic                   resyncEnable,
    output logic                   standstillBrakeEnable,
    output logic                   brakingSwitchSelect,
    output logic                   brakingExitSelect,
    output logic                   parityBit,
    // raw codes
    output logic      [2:0]        standstillEmfThreshold,
    output logic      [2:0]        brakingCurrentLimit,
    output logic      [3:0]        brakingDuration,
    output logic      [2:0]        standstillBrakingDuration,
    output logic      [2:0]        resyncMinEmf,
    // decoded values
    output logic      [6:0]        standstillEmfMv,
    output logic      [6:0]        brakingCurrentMv,
    output logic      [13:0]       brakingDurationMs,
    output logic      [13:0]       floatDurationMs,
    output logic      [9:0]        standstillBrakingMs,
    output logic      [10:0]       resyncMinEmfMv
);

    // ************************************************************
    // address decode
    // ************************************************************
    sdb_state_s          st;
    sdb_state_s          next_st;
    logic [NUM_REGS-1:0] hit;
    logic [31:0]         detWord;

    // one comparator per mapped offset
    // a full-width compare, so gap and odd offsets miss every word
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++)
        begin : g_hit
            assign hit[gi] = (cfgAddr == REG_OFFS[gi]);
        end
    endgenerate

    // ************************************************************
    // next state
    // ************************************************************
    // reads see the word before a same-cycle write lands, so a combined
    // read and write to one word returns the old value and stores the new;
    // unmapped offsets store nothing and read as zero
    always_comb
    begin
        next_st         = st;
        next_st.rdValid = 1'b0;
        next_st.addrErr = 1'b0;
        if (cfgWrite)
        begin
            for (int i = 0; i < NUM_REGS; i++)
            begin
                if (hit[i])
                begin
                    next_st.bank[i] = cfgWrData;
                end
            end
            if (hit == '0)
            begin
                next_st.addrErr = 1'b1;
            end
        end
        if (cfgRead)
        begin
            next_st.rdValid = 1'b1;
            next_st.rdData  = RESET_VAL; // unmapped reads return zero
            for (int i = 0; i < NUM_REGS; i++)
            begin
                if (hit[i])
                begin
                    next_st.rdData = st.bank[i];
                end
            end
            if (hit == '0)
            begin
                next_st.addrErr = 1'b1;
            end
        end
        // decode from the new word so codes and values move together
        next_st.emfMv    = THR_MV[next_st.bank[DET_IDX][EMF_THR_LSB +: 3]];
        next_st.curMv    = THR_MV[next_st.bank[DET_IDX][CUR_LIM_LSB +: 3]];
        next_st.brkMs    = DUR_MS[next_st.bank[DET_IDX][BRK_DUR_LSB +: 4]];
        next_st.floatMs  = DUR_MS[next_st.bank[DET_IDX][FLOAT_DUR_LSB +: 4]];
        next_st.standMs  = STAND_MS[next_st.bank[DET_IDX][STAND_DUR_LSB +: 3]];
        next_st.resyncMv = RESYNC_MV[next_st.bank[DET_IDX][RESYNC_MV_LSB +: 3]];
    end

    // ************************************************************
    // state register
    // ************************************************************
    // all words clear to zero; decoded values follow code zero, so the
    // algorithm never sees a decoded value that disagrees with its code
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st          <= '0;
            st.emfMv    <= THR_MV[0];
            st.curMv    <= THR_MV[0];
            st.brkMs    <= DUR_MS[0];
            st.floatMs  <= DUR_MS[0];
            st.standMs  <= STAND_MS[0];
            st.resyncMv <= RESYNC_MV[0];
        end
        else
        begin
            st <= next_st;
        end
    end

    // ************************************************************
    // outputs, all taken from the state flops
    // ************************************************************
    // register port answers
    assign cfgRdData                 = st.rdData;
    assign cfgRdValid                = st.rdValid;
    assign cfgAddrErr                = st.addrErr;

    // single-bit settings, one stored bit each
    assign detWord                   = st.bank[DET_IDX];
    assign parityBit                 = detWord[PARITY_BIT];
    assign speedDetectEnable         = detWord[DETECT_EN_BIT];
    assign brakeEnable               = detWord[BRAKE_EN_BIT];
    assign floatOutputsEnable        = detWord[FLOAT_EN_BIT];
    assign reverseDriveEnable        = detWord[REVERSE_BIT];
    assign resyncEnable              = detWord[RESYNC_BIT];
    assign standstillBrakeEnable     = detWord[STAND_BRK_BIT];
    assign brakingSwitchSelect       = detWord[SWITCH_BIT];
    assign brakingExitSelect         = detWord[EXIT_SEL_BIT];

    // raw codes handed to the algorithm as stored
    assign standstillEmfThreshold    = detWord[EMF_THR_LSB +: 3];
    assign brakingCurrentLimit       = detWord[CUR_LIM_LSB +: 3];
    assign brakingDuration           = detWord[BRK_DUR_LSB +: 4];
    assign standstillBrakingDuration = detWord[STAND_DUR_LSB +: 3];
    assign resyncMinEmf              = detWord[RESYNC_MV_LSB +: 3];

    // decoded values, registered beside their codes so both move on one edge
    assign standstillEmfMv           = st.emfMv;
    assign brakingCurrentMv          = st.curMv;
    assign brakingDurationMs         = st.brkMs;
    assign floatDurationMs           = st.floatMs;
    assign standstillBrakingMs       = st.standMs;
    assign resyncMinEmfMv            = st.resyncMv;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // a write that lands in the speed-detect word this cycle
    logic detWr;
    assign detWr = cfgWrite && hit[DET_IDX];

    // ************************************************************
    // register port protocol
    // ************************************************************
    // every read and every unmapped access answers exactly one edge later; a late or missing
    // pulse would make software pair answers with the wrong request
    a_bad_addr_flag: assert property ((cfgWrite || cfgRead) && hit == '0 |=> cfgAddrErr)
        else $error("unmapped access not flagged");
    a_addr_quiet: assert property (!((cfgWrite || cfgRead) && hit == '0) |=> !cfgAddrErr)
        else $error("address error without unmapped access");
    a_bad_read_zero: assert property (cfgRead && hit == '0 |=> cfgRdData == 32'h0)
        else $error("unmapped read not zero");
    a_bad_write_keep: assert property (cfgWrite && hit == '0 |=> $stable(st.bank))
        else $error("unmapped write changed a stored word");
    a_read_pulse: assert property (cfgRead |=> cfgRdValid)
        else $error("read not answered");
    a_no_stray_valid: assert property (!cfgRead |=> !cfgRdValid)
        else $error("read valid without a read");
    a_rd_hold: assert property (!cfgRead |=> $stable(cfgRdData))
        else $error("read data moved without a read");
    a_detect_readback: assert property (detWr ##1 (cfgRead && hit[DET_IDX])
            |=> cfgRdValid && cfgRdData == $past(cfgWrData, 2))
        else $error("speed-detect word read back wrong");

    // the word is cleared by reset, so the first edge after release must
    // still show zero fields and the code-zero braking duration
    a_reset_clear: assert property ($rose(reset_n) |-> detWord == 32'h0 && brakingDurationMs == 14'h000a)
        else $error("speed-detect word not clear after reset");
    a_word_hold: assert property (!detWr |=> $stable(detWord))
        else $error("speed-detect word changed without a write");

    // ************************************************************
    // field storage
    // ************************************************************
    // each enable and code follows its own bit of the written word; the
    // literal bit numbers here keep a slipped field position visible
    a_detect_enable: assert property (detWr |=> speedDetectEnable == $past(cfgWrData[30]))
        else $error("detect enable not stored");
    a_brake_enable: assert property (detWr |=> brakeEnable == $past(cfgWrData[29]))
        else $error("brake enable not stored");
    a_float_enable: assert property (detWr |=> floatOutputsEnable == $past(cfgWrData[28]))
        else $error("float enable not stored");
    a_reverse_enable: assert property (detWr |=> reverseDriveEnable == $past(cfgWrData[27]))
        else $error("reverse enable not stored");
    a_resync_enable: assert property (detWr |=> resyncEnable == $past(cfgWrData[26]))
        else $error("resync enable not stored");
    a_stand_brake: assert property (detWr |=> standstillBrakeEnable == $past(cfgWrData[25]))
        else $error("standstill brake not stored");
    a_switch_sel: assert property (detWr |=> brakingSwitchSelect == $past(cfgWrData[21]))
        else $error("switch select not stored");
    a_exit_sel: assert property (detWr |=> brakingExitSelect == $past(cfgWrData[20]))
        else $error("exit select not stored");
    a_parity_bit: assert property (detWr |=> parityBit == $past(cfgWrData[31]))
        else $error("parity bit not stored");
    a_emf_code: assert property (detWr |=> standstillEmfThreshold == $past(cfgWrData[24:22]))
        else $error("emf threshold code not stored");
    a_cur_code: assert property (detWr |=> brakingCurrentLimit == $past(cfgWrData[19:17]))
        else $error("current limit code not stored");
    a_dur_code: assert property (detWr |=> brakingDuration == $past(cfgWrData[16:13]))
        else $error("brake duration code not stored");
    a_stand_code: assert property (detWr |=> standstillBrakingDuration == $past(cfgWrData[8:6]))
        else $error("standstill duration code not stored");
    a_resync_code: assert property (detWr |=> resyncMinEmf == $past(cfgWrData[5:3]))
        else $error("resync emf code not stored");

    // ************************************************************
    // decoded values
    // ************************************************************
    // table end points and a few inner codes; the tables are not linear,
    // so inner points catch a shifted entry that the ends would miss
    a_emf_top: assert property (standstillEmfThreshold == 3'h7 |-> standstillEmfMv == 7'h64)
        else $error("emf threshold code 7 not 100 mV");
    a_emf_low: assert property (standstillEmfThreshold == 3'h0 |-> standstillEmfMv == 7'h05)
        else $error("emf threshold code 0 not 5 mV");
    a_emf_code6: assert property (standstillEmfThreshold == 3'h6 |-> standstillEmfMv == 7'h32)
        else $error("emf threshold code 6 not 50 mV");
    a_cur_code6: assert property (brakingCurrentLimit == 3'h6 |-> brakingCurrentMv == 7'h32)
        else $error("current code 6 not 50 mV");
    a_cur_top: assert property (brakingCurrentLimit == 3'h7 |-> brakingCurrentMv == 7'h64)
        else $error("current code 7 not 100 mV");
    a_dur_top: assert property (brakingDuration == 4'hf |-> brakingDurationMs == 14'h3a98)
        else $error("brake code f not 15 s");
    a_dur_low: assert property (brakingDuration == 4'h0 |-> brakingDurationMs == 14'h000a)
        else $error("brake code 0 not 10 ms");
    a_dur_one_sec: assert property (brakingDuration == 4'h8 |-> brakingDurationMs == 14'h03e8)
        else $error("brake code 8 not 1 s");
    a_dur_mid: assert property (brakingDuration == 4'hd |-> brakingDurationMs == 14'h1d4c)
        else $error("brake code d not 7.5 s");
    a_stand_dur: assert property (standstillBrakingDuration == 3'h0 |-> standstillBrakingMs == 10'h001)
        else $error("standstill code 0 not 1 ms");
    a_stand_top: assert property (standstillBrakingDuration == 3'h7 |-> standstillBrakingMs == 10'h3e8)
        else $error("standstill code 7 not 1000 ms");
    a_resync_min: assert property (resyncMinEmf == 3'h0 |-> resyncMinEmfMv == 11'h000)
        else $error("resync code 0 not derived");
    a_resync_low: assert property (resyncMinEmf == 3'h1 |-> resyncMinEmfMv == 11'h12c)
        else $error("resync code 1 not 300 mV");
    a_resync_top: assert property (resyncMinEmf == 3'h7 |-> resyncMinEmfMv == 11'h4e2)
        else $error("resync code 7 not 1250 mV");

    // ************************************************************
    // scenarios worth seeing
    // ************************************************************
    // the combined read and write is the case most likely to go unexercised
    c_detect_write: cover property (detWr ##1 speedDetectEnable);
    c_detect_read: cover property (cfgRead && hit[DET_IDX] ##1 cfgRdValid);
    c_bad_addr: cover property (cfgAddrErr);
    c_long_brake: cover property (brakingDuration == 4'hf);
    c_write_read_same: cover property (detWr && cfgRead);

endmodule

// ==== test/sdb_config_bank_tb.sv ====
// self-checking bench for the speed-detect / brake configuration bank
// assumes sdb_pkg is compiled first; the bench drives the register port itself
`timescale 1ns/1ns

module testbench
    import sdb_pkg::*;
;
    // ****************************************************************
    // signals and reference model
    // ****************************************************************
    logic              ref_clk, reset_n, cfgWrite, cfgRead;
    logic [ADDR_W-1:0] cfgAddr;
    logic [31:0]       cfgWrData, cfgRdData, w;
    logic              cfgRdValid, cfgAddrErr, speedDetectEnable, brakeEnable, floatOutputsEnable;
    logic              reverseDriveEnable, resyncEnable, standstillBrakeEnable, brakingSwitchSelect;
    logic              brakingExitSelect, parityBit;
    logic [2:0]        standstillEmfThreshold, brakingCurrentLimit, standstillBrakingDuration, resyncMinEmf;
    logic [3:0]        brakingDuration;
    logic [6:0]        standstillEmfMv, brakingCurrentMv;
    logic [13:0]       brakingDurationMs, floatDurationMs;
    logic [9:0]        standstillBrakingMs;
    logic [10:0]       resyncMinEmfMv;
    logic [31:0]       mdl [NUM_REGS];
    logic [31:0]       rdQ [$];
    logic              errQ [$];
    logic [11:0]       bad [5] = '{12'h081, 12'h092, 12'h094, 12'h07e, 12'h09e};
    int                errors, cmpCount, seed;
    // physical value tables kept apart from the design's own
    int mvT [8]  = '{5, 10, 15, 20, 25, 30, 50, 100};
    int msT [16] = '{10, 50, 100, 200, 300, 400, 500, 750, 1000, 2000, 3000, 4000, 5000, 7500, 10000, 15000};
    int smT [8]  = '{1, 10, 25, 50, 100, 250, 500, 1000};
    int rmT [8]  = '{0, 300, 400, 500, 600, 800, 1000, 1250};

    sdb_config_bank i_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr),
        .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .cfgAddrErr(cfgAddrErr),
        .speedDetectEnable(speedDetectEnable), .brakeEnable(brakeEnable), .floatOutputsEnable(floatOutputsEnable),
        .reverseDriveEnable(reverseDriveEnable), .resyncEnable(resyncEnable),
        .standstillBrakeEnable(standstillBrakeEnable), .brakingSwitchSelect(brakingSwitchSelect),
        .brakingExitSelect(brakingExitSelect), .parityBit(parityBit),
        .standstillEmfThreshold(standstillEmfThreshold), .brakingCurrentLimit(brakingCurrentLimit),
        .brakingDuration(brakingDuration), .standstillBrakingDuration(standstillBrakingDuration),
        .resyncMinEmf(resyncMinEmf), .standstillEmfMv(standstillEmfMv), .brakingCurrentMv(brakingCurrentMv),
        .brakingDurationMs(brakingDurationMs), .floatDurationMs(floatDurationMs),
        .standstillBrakingMs(standstillBrakingMs), .resyncMinEmfMv(resyncMinEmfMv));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmpCount++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmpCount, errors);
        if (errors == 0 && cmpCount > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    function automatic int idx(input logic [11:0] a);
        idx = -1;
        for (int k = 0; k < NUM_REGS; k++) if (REG_OFFS[k] == a) idx = k;
    endfunction

    // one request per call, held across exactly one sampling edge
    task automatic req(input logic wr, input logic rd, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = idx(a);
        cfgWrite = wr;
        cfgRead = rd;
        cfgAddr = a;
        cfgWrData = d;
        if (rd) rdQ.push_back(k < 0 ? 32'h0 : mdl[k]); // read sees the old word even with a write beside it
        if ((rd || wr) && k < 0) errQ.push_back(1'b1);
        if (wr && k >= 0) mdl[k] = d;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic fields(input logic [31:0] v);
        chk("parityBit", v[31], parityBit);
        chk("speedDetectEnable", v[30], speedDetectEnable);
        chk("brakeEnable", v[29], brakeEnable);
        chk("floatOutputsEnable", v[28], floatOutputsEnable);
        chk("reverseDriveEnable", v[27], reverseDriveEnable);
        chk("resyncEnable", v[26], resyncEnable);
        chk("standstillBrakeEnable", v[25], standstillBrakeEnable);
        chk("standstillEmfThreshold", v[24:22], standstillEmfThreshold);
        chk("standstillEmfMv", mvT[v[24:22]], standstillEmfMv);
        chk("brakingSwitchSelect", v[21], brakingSwitchSelect);
        chk("brakingExitSelect", v[20], brakingExitSelect);
        chk("brakingCurrentLimit", v[19:17], brakingCurrentLimit);
        chk("brakingCurrentMv", mvT[v[19:17]], brakingCurrentMv);
        chk("brakingDuration", v[16:13], brakingDuration);
        chk("brakingDurationMs", msT[v[16:13]], brakingDurationMs);
        chk("floatDurationMs", msT[v[12:9]], floatDurationMs);
        chk("standstillBrakingDuration", v[8:6], standstillBrakingDuration);
        chk("standstillBrakingMs", smT[v[8:6]], standstillBrakingMs);
        chk("resyncMinEmf", v[5:3], resyncMinEmf);
        chk("resyncMinEmfMv", rmT[v[5:3]], resyncMinEmfMv);
    endtask

    // reset is only entered while idle so no answer is lost in flight
    task automatic do_reset();
        reset_n = 1'b0;
        foreach (mdl[k]) mdl[k] = 32'h0;
        repeat (3) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
    endtask

    // ****************************************************************
    // clock, answer monitor and watchdog
    // ****************************************************************
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // sampled at the falling edge, when registered answers have settled
    always @(negedge ref_clk)
    begin
        if (cfgRdValid !== 1'b0)
        begin
            chk("cfgRdValid", 32'h1, cfgRdValid);
            chk("cfgRdData", rdQ.size() > 0 ? rdQ.pop_front() : 32'hdead_beef, cfgRdData);
        end
        if (cfgAddrErr !== 1'b0)
        begin
            chk("cfgAddrErr", 32'(errQ.size() > 0), cfgAddrErr);
            if (errQ.size() > 0) void'(errQ.pop_front());
        end
    end

    initial
    begin
        repeat (4000) @(posedge ref_clk);
        errors++;
        conclude();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        seed = 92;
        {cfgWrite, cfgRead, cfgAddr, cfgWrData} = '0;
        do_reset();
        fields(32'h0);
        for (int i = 0; i < NUM_REGS; i++) req(1'b0, 1'b1, REG_OFFS[i], 32'h0);
        for (int i = 0; i < NUM_REGS; i++) req(1'b1, 1'b0, REG_OFFS[i], $random(seed));
        for (int i = 0; i < NUM_REGS; i++) req(1'b0, 1'b1, REG_OFFS[i], 32'h0);
        // every code of every field, with random enables around it
        for (int c = 0; c < 18; c++)
        begin
            w = (c == 16) ? 32'hffff_ffff : (c == 17) ? 32'h0 : $random(seed);
            if (c < 16) w[12:9] = c[3:0];
            if (c < 16) {w[24:22], w[19:17], w[16:13], w[8:6], w[5:3]} = {c[2:0], c[2:0], c[3:0], c[2:0], c[2:0]};
            req(1'b1, 1'b0, 12'h080, w);
            fields(mdl[DET_IDX]);
        end
        req(1'b1, 1'b1, 12'h080, $random(seed));
        req(1'b0, 1'b1, 12'h080, 32'h0);
        // unlisted offsets store nothing and read as zero
        foreach (bad[k])
        begin
            req(1'b1, 1'b0, bad[k], $random(seed));
            req(1'b0, 1'b1, bad[k], 32'h0);
        end
        fields(mdl[DET_IDX]);
        req(1'b0, 1'b0, 12'h000, 32'h0);
        do_reset();
        fields(32'h0);
        req(1'b0, 1'b1, 12'h080, 32'h0);
        repeat (3) req(1'b0, 1'b0, 12'h000, 32'h0);
        chk("pendingAnswers", 32'h0, 32'(rdQ.size() + errQ.size()));
        conclude();
    end
endmodule
